// file: csb_codec_model.sv
// Purpose: behavioural codec on the far side of the serial link
// Assumes: codec supplies a free-running 200 ns bit clock
// Notes: outputs move 50 ns after a rise, clear of the sampling fall
`timescale 1ns/100ps
`default_nettype none
module csb_codec_model (
  input wire logic active,
  input wire logic [15:0] pattern,
  output logic bit_clock,
  output logic frame_sync,
  output logic data_out
);
  int bit_cnt;
  initial begin
    bit_clock = 1'b0;
    frame_sync = 1'b0;
    data_out = 1'b0;
    bit_cnt = 0;
  end
  always #100 bit_clock = ~bit_clock;
  // sync bit, gap bit, then sixteen bits msb first
  always @(posedge bit_clock) begin
    bit_cnt = (bit_cnt == 17) ? 0 : bit_cnt + 1;
    #50;
    frame_sync = active && bit_cnt == 0;
    if (active && bit_cnt >= 2) begin
      data_out = pattern[17 - bit_cnt];
    end else begin
      // released line keeps moving so stale bits cannot pass
      data_out = ~data_out;
    end
  end
endmodule
`default_nettype wire

// file: csb_defs.vh
// Purpose: constants for the codec slot buffer control block
// Assumes: word-addressed register bus, 16-bit registers in low data bits
// Notes: definitions only
`ifndef CSB_DEFS_VH
`define CSB_DEFS_VH

// register word addresses
`define CSB_REG_CTRL_A 4'h0
`define CSB_REG_CTRL_B 4'h1
`define CSB_REG_STATUS 4'h2
`define CSB_REG_TX_SLOT 4'h3
`define CSB_REG_RX_SLOT 4'h4
`define CSB_REG_TX_BUF0 4'h5
`define CSB_REG_TX_BUF3 4'h8
`define CSB_REG_RX_BUF0 4'h9
`define CSB_REG_RX_BUF3 4'hC

// control a fields
`define CSB_A_LOOP 0
`define CSB_A_UNUSED_DRV 1
`define CSB_A_UNF_POLICY 2
`define CSB_A_STOP_IDLE 3
`define CSB_A_FSM_LO 4
`define CSB_A_FSM_HI 5
`define CSB_A_FS_SLAVE 6
`define CSB_A_BCLK_EXT 7
`define CSB_A_ENABLE 8

// control b fields
`define CSB_B_BUFFER_LENGTH_FIELD_LO 0
`define CSB_B_BUFFER_LENGTH_FIELD_HI 1
`define CSB_B_FL_LO 4
`define CSB_B_FL_HI 7
`define CSB_B_WS_LO 8
`define CSB_B_WS_HI 11

// status fields
`define CSB_S_TX_EMPTY 0
`define CSB_S_TX_UNF 1
`define CSB_S_RX_FULL 2
`define CSB_S_RX_OVF 3
`define CSB_S_SLOT_LO 8
`define CSB_S_SLOT_HI 11

// reset values
`define CSB_CTRL_A_RST 16'h0000
`define CSB_CTRL_B_RST 16'h0000
`define CSB_SLOT_EN_RST 16'h0000

// frame sync modes
`define CSB_FSM_MULTI 2'h0
`define CSB_FSM_AC16 2'h2
`define CSB_FSM_AC20 2'h3

// link geometry
`define CSB_AC16_LAST_SLOT 4'hC
`define CSB_AC_SLOT0_LAST 5'h0F
`define CSB_AC_DATA_LAST 5'h13
`define CSB_AC20_FIELD 4'hF

// timing
`define CSB_CLK_PERIOD_NS 25
`define CSB_BCLK_HALF_NS 125
`define CSB_BCLK_HALF_CYC ((`CSB_BCLK_HALF_NS + `CSB_CLK_PERIOD_NS - 1) / `CSB_CLK_PERIOD_NS)

`endif

// file: csb_sync.v
// Purpose: two-flop synchroniser for pins entering the CLOCK domain
// Assumes: synchronous active-low reset
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module csb_sync (
  input wire CLOCK,
  input wire RESET_N,
  input wire CLK_EN,
  input wire [2:0] D,
  output reg [2:0] Q
);
  reg [2:0] meta_reg;

  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      meta_reg <= 3'h0;
      Q <= 3'h0;
    end else if (CLK_EN) begin
      meta_reg <= D;
      Q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: csb_top.v
// Purpose: slot gating, buffering, status and frame logic of a codec serial port
// Assumes: Avalon-MM slave with waitrequest, word addresses, one-wait-cycle answer
// Notes: link pins are sampled by CLOCK; bit clock at most CLOCK/4
// Contract
// - master emits frame sync at generator reset
// - slave frame sync resets frame generator
// - stop buffering after last enabled slot
// - counter advances once per enabled slot
// - counter match length: clear, swap shadows
// - dma request on each transfer flag
// - tx empty set at transfer, cleared by write
// - tx underflow set if unrefilled, cleared write
// - rx full until all used buffers read
// - unread rx overwritten, overflow until read
// - flags see only buffers in use; tx empty here clears on a write to any of the four tx buffers
// - slot status shows generator slot count
// - disabled slot drives low or floats
// - loopback feeds output to input internally
// - underflow sends zeros or last word
// - interrupt at every shadow transfer
// - runs in sleep on external clock, wakes
// - stop-in-idle halts module in idle
// - mode 10 ac16, 11 ac20, 256-bit frame
// - ac16 truncates rx, zeros four tx lsbs
// - ac20 sync high 16, low 240 cycles
// - ac20 acts as sixteen 16-bit slots
// - buffer length one to four words
// - direction bit selects external bit clock
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`include "csb_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module csb_top (
  input wire CLOCK,
  input wire RESET_N,
  input wire CLK_EN,
  input wire CORE_SLEEP,
  input wire CORE_IDLE,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  input wire SERIAL_DATA_IN,
  output reg SERIAL_DATA_OUT,
  output reg SERIAL_DATA_OE_N,
  input wire FRAME_SYNC_PIN_IN,
  output reg FRAME_SYNC_PIN_OUT,
  output reg FRAME_SYNC_PIN_OE_N,
  input wire SERIAL_BIT_CLOCK_IN,
  output reg SERIAL_BIT_CLOCK_OUT,
  output reg SERIAL_BIT_CLOCK_OE_N,
  output reg CODEC_IRQ_FLAG,
  output reg DMA_REQ,
  output reg WAKE_IRQ
);
  function [3:0] in_use;
    input [1:0] buffer_length_field;
    begin
      case (buffer_length_field)
        2'h0: in_use = 4'h1;
        2'h1: in_use = 4'h3;
        2'h2: in_use = 4'h7;
        default: in_use = 4'hF;
      endcase
    end
  endfunction

  function [4:0] slot_last;
    input [3:0] slot;
    input ac16;
    input [3:0] ws;
    begin
      if (ac16)
        slot_last = (slot == 4'h0) ? `CSB_AC_SLOT0_LAST : `CSB_AC_DATA_LAST;
      else
        slot_last = {1'b0, ws};
    end
  endfunction

  function [15:0] merge;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    reg [15:0] m;
    begin
      m = {{8{be[1]}}, {8{be[0]}}};
      merge = (old & ~m) | (wd[15:0] & m);
    end
  endfunction

  reg [15:0] ctrl_a_reg;
  reg [15:0] ctrl_b_reg;
  reg [15:0] tse_reg;
  reg [15:0] rse_reg;
  reg [15:0] tx_buf_reg [0:3];
  reg [15:0] tx_sh_reg [0:3];
  reg [15:0] rx_buf_reg [0:3];
  reg [15:0] rx_sh_reg [0:3];
  reg [3:0] tx_fresh_reg;
  reg [3:0] tx_unf_reg;
  reg [3:0] rx_new_reg;
  reg [3:0] rx_ovf_reg;
  reg tx_empty_reg;
  reg [1:0] ptr_reg;
  reg [3:0] slot_reg;
  reg [4:0] bit_reg;
  reg active_reg;
  reg pend_reg;
  reg [15:0] rx_word_reg;
  reg bclk_d_reg;
  reg [7:0] div_reg;
  reg [2:0] k;

  wire [2:0] pins_s;
  csb_sync u_sync (
    .CLOCK(CLOCK),
    .RESET_N(RESET_N),
    .CLK_EN(CLK_EN),
    .D({SERIAL_BIT_CLOCK_IN, FRAME_SYNC_PIN_IN, SERIAL_DATA_IN}),
    .Q(pins_s)
  );
  wire bclk_s = pins_s[2];
  wire fs_s = pins_s[1];
  wire sdi_s = pins_s[0];

  wire [1:0] fsm = ctrl_a_reg[`CSB_A_FSM_HI:`CSB_A_FSM_LO];
  wire ac16 = (fsm == `CSB_FSM_AC16);
  wire ac20 = (fsm == `CSB_FSM_AC20);
  wire is_ac = ac16 | ac20;
  wire slave = ctrl_a_reg[`CSB_A_FS_SLAVE];
  wire ext_clk = ctrl_a_reg[`CSB_A_BCLK_EXT];
  wire [1:0] buffer_length_field = ctrl_b_reg[`CSB_B_BUFFER_LENGTH_FIELD_HI:`CSB_B_BUFFER_LENGTH_FIELD_LO];
  wire [3:0] used = in_use(buffer_length_field);
  // ac20 forces frame length and word size to all ones
  wire [3:0] eff_fl = ac20 ? `CSB_AC20_FIELD :
    (ac16 ? `CSB_AC16_LAST_SLOT : ctrl_b_reg[`CSB_B_FL_HI:`CSB_B_FL_LO]);
  wire [3:0] eff_ws = ac20 ? `CSB_AC20_FIELD : ctrl_b_reg[`CSB_B_WS_HI:`CSB_B_WS_LO];
  wire [4:0] last_bit = slot_last(slot_reg, ac16, eff_ws);
  wire bit_end = (bit_reg == last_bit);
  wire frame_end = bit_end && (slot_reg == eff_fl);

  // sleep halts only an internal bit clock; idle halts on request
  wire run = ctrl_a_reg[`CSB_A_ENABLE] & ~(CORE_IDLE & ctrl_a_reg[`CSB_A_STOP_IDLE]) &
    ~(CORE_SLEEP & ~ext_clk);
  // last divider count of a half period in CLOCK cycles, cut to the divider width
  wire [31:0] div_last = `CSB_BCLK_HALF_CYC - 1;
  wire div_tick = (div_reg == div_last[7:0]);
  wire rise_i = div_tick & ~SERIAL_BIT_CLOCK_OUT;
  wire fall_i = div_tick & SERIAL_BIT_CLOCK_OUT;
  wire rise = run & (ext_clk ? (bclk_s & ~bclk_d_reg) : rise_i);
  wire fall = run & (ext_clk ? (~bclk_s & bclk_d_reg) : fall_i);

  // frame generator next state at a rising bit-clock edge
  reg [3:0] slot_n;
  reg [4:0] bit_n;
  reg act_n;
  reg fstart;
  reg pend_n;
  always @* begin
    slot_n = slot_reg;
    bit_n = bit_reg;
    act_n = active_reg;
    fstart = 1'b0;
    pend_n = pend_reg;
    if (active_reg && !frame_end) begin
      if (bit_end) begin
        bit_n = 5'h00;
        slot_n = slot_reg + 4'h1;
      end else begin
        bit_n = bit_reg + 5'h01;
      end
    end else if (active_reg && slave) begin
      act_n = 1'b0;
    end else if (!slave || pend_reg) begin
      fstart = 1'b1;
      act_n = 1'b1;
      pend_n = 1'b0;
      slot_n = 4'h0;
      bit_n = 5'h00;
    end else if (fs_s) begin
      pend_n = 1'b1;
    end
  end

  wire [15:0] cur_tx = tx_sh_reg[ptr_reg];
  wire drive_n = act_n & tse_reg[slot_n];
  // ac16 pads 20-bit slots with four zero lsbs
  wire data_n = (bit_n < 5'h10) ? cur_tx[~bit_n[3:0]] : 1'b0;

  wire din = ctrl_a_reg[`CSB_A_LOOP] ? SERIAL_DATA_OUT : sdi_s;
  wire rx_bit_ok = rse_reg[slot_reg] && (bit_reg < 5'h10);
  reg [15:0] rx_val;
  always @* begin
    rx_val = rx_word_reg;
    if (rx_bit_ok)
      rx_val[~bit_reg[3:0]] = din;
  end
  wire slot_done = fall & active_reg & bit_end;
  wire consume = slot_done & (tse_reg[slot_reg] | rse_reg[slot_reg]);
  wire xfer = consume & (ptr_reg == buffer_length_field);

  wire acc = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
  wire wr = acc & AVS_WRITE;
  wire rd = acc & AVS_READ;
  wire tx_hit = (AVS_ADDRESS >= `CSB_REG_TX_BUF0) && (AVS_ADDRESS <= `CSB_REG_TX_BUF3);
  wire rx_hit = (AVS_ADDRESS >= `CSB_REG_RX_BUF0) && (AVS_ADDRESS <= `CSB_REG_RX_BUF3);
  wire [3:0] tx_off = AVS_ADDRESS - `CSB_REG_TX_BUF0;
  wire [3:0] rx_off = AVS_ADDRESS - `CSB_REG_RX_BUF0;

  wire tx_unf_any = |(tx_unf_reg & used);
  wire rx_full_any = |(rx_new_reg & used);
  wire rx_ovf_any = |(rx_ovf_reg & used);

  reg [15:0] rd_val;
  always @* begin
    rd_val = 16'h0000;
    case (AVS_ADDRESS)
      `CSB_REG_CTRL_A: rd_val = ctrl_a_reg;
      `CSB_REG_CTRL_B: rd_val = ctrl_b_reg;
      `CSB_REG_STATUS: begin
        rd_val[`CSB_S_TX_EMPTY] = tx_empty_reg;
        rd_val[`CSB_S_TX_UNF] = tx_unf_any;
        rd_val[`CSB_S_RX_FULL] = rx_full_any;
        rd_val[`CSB_S_RX_OVF] = rx_ovf_any;
        rd_val[`CSB_S_SLOT_HI:`CSB_S_SLOT_LO] = slot_reg;
      end
      `CSB_REG_TX_SLOT: rd_val = tse_reg;
      `CSB_REG_RX_SLOT: rd_val = rse_reg;
      default: begin
        if (tx_hit)
          rd_val = tx_buf_reg[tx_off[1:0]];
        else if (rx_hit)
          rd_val = rx_buf_reg[rx_off[1:0]];
      end
    endcase
  end

  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      ctrl_a_reg <= `CSB_CTRL_A_RST;
      ctrl_b_reg <= `CSB_CTRL_B_RST;
      tse_reg <= `CSB_SLOT_EN_RST;
      rse_reg <= `CSB_SLOT_EN_RST;
      for (k = 3'h0; k < 3'h4; k = k + 3'h1) begin
        tx_buf_reg[k[1:0]] <= 16'h0000;
        tx_sh_reg[k[1:0]] <= 16'h0000;
        rx_buf_reg[k[1:0]] <= 16'h0000;
        rx_sh_reg[k[1:0]] <= 16'h0000;
      end
      tx_fresh_reg <= 4'h0;
      tx_unf_reg <= 4'h0;
      rx_new_reg <= 4'h0;
      rx_ovf_reg <= 4'h0;
      tx_empty_reg <= 1'b0;
      ptr_reg <= 2'h0;
      slot_reg <= 4'h0;
      bit_reg <= 5'h00;
      active_reg <= 1'b0;
      pend_reg <= 1'b0;
      rx_word_reg <= 16'h0000;
      bclk_d_reg <= 1'b0;
      div_reg <= 8'h00;
      AVS_READDATA <= 32'h00000000;
      AVS_WAITREQUEST <= 1'b1;
      SERIAL_DATA_OUT <= 1'b0;
      SERIAL_DATA_OE_N <= 1'b1;
      FRAME_SYNC_PIN_OUT <= 1'b0;
      FRAME_SYNC_PIN_OE_N <= 1'b1;
      SERIAL_BIT_CLOCK_OUT <= 1'b0;
      SERIAL_BIT_CLOCK_OE_N <= 1'b1;
      CODEC_IRQ_FLAG <= 1'b0;
      DMA_REQ <= 1'b0;
      WAKE_IRQ <= 1'b0;
    end else if (CLK_EN) begin
      // bus slave: one wait cycle, then a one-cycle answer
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
      if (AVS_READ & AVS_WAITREQUEST)
        AVS_READDATA <= {16'h0000, rd_val};
      if (wr) begin
        case (AVS_ADDRESS)
          `CSB_REG_CTRL_A: ctrl_a_reg <= merge(ctrl_a_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          `CSB_REG_CTRL_B: ctrl_b_reg <= merge(ctrl_b_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          `CSB_REG_TX_SLOT: tse_reg <= merge(tse_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          `CSB_REG_RX_SLOT: rse_reg <= merge(rse_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          default: begin
            if (tx_hit)
              tx_buf_reg[tx_off[1:0]] <=
                merge(tx_buf_reg[tx_off[1:0]], AVS_WRITEDATA, AVS_BYTEENABLE);
          end
        endcase
      end

      // internal bit clock, driven out only when not taken from outside
      bclk_d_reg <= bclk_s;
      SERIAL_BIT_CLOCK_OE_N <= ext_clk;
      if (!run || ext_clk) begin
        div_reg <= 8'h00;
      end else if (div_tick) begin
        div_reg <= 8'h00;
        SERIAL_BIT_CLOCK_OUT <= ~SERIAL_BIT_CLOCK_OUT;
      end else begin
        div_reg <= div_reg + 8'h01;
      end

      FRAME_SYNC_PIN_OE_N <= slave;
      if (!ctrl_a_reg[`CSB_A_ENABLE]) begin
        active_reg <= 1'b0;
        pend_reg <= 1'b0;
      end else if (rise) begin
        slot_reg <= slot_n;
        bit_reg <= bit_n;
        active_reg <= act_n;
        pend_reg <= pend_n;
        // ac sync covers the 16-bit tag slot, then stays low 240 bits
        FRAME_SYNC_PIN_OUT <= ~slave & (is_ac ? (act_n & (slot_n == 4'h0)) : fstart);
        SERIAL_DATA_OUT <= drive_n & data_n;
        SERIAL_DATA_OE_N <= ~drive_n & ctrl_a_reg[`CSB_A_UNUSED_DRV];
      end

      if (fall && active_reg) begin
        rx_word_reg <= bit_end ? 16'h0000 : rx_val;
        if (consume) begin
          if (rse_reg[slot_reg])
            rx_sh_reg[ptr_reg] <= rx_val;
          ptr_reg <= xfer ? 2'h0 : ptr_reg + 2'h1;
        end
      end

      // flags: a transfer in the same cycle as a clear wins
      for (k = 3'h0; k < 3'h4; k = k + 3'h1) begin
        if (wr && tx_hit && tx_off[1:0] == k[1:0]) begin
          tx_fresh_reg[k[1:0]] <= 1'b1;
          if (!(xfer && used[k[1:0]]))
            tx_unf_reg[k[1:0]] <= 1'b0;
        end else if (xfer && used[k[1:0]]) begin
          tx_fresh_reg[k[1:0]] <= 1'b0;
        end
        if (rd && rx_hit && rx_off[1:0] == k[1:0] && !(xfer && used[k[1:0]])) begin
          rx_new_reg[k[1:0]] <= 1'b0;
          rx_ovf_reg[k[1:0]] <= 1'b0;
        end
        if (xfer && used[k[1:0]]) begin
          if (tx_fresh_reg[k[1:0]] || ctrl_a_reg[`CSB_A_UNF_POLICY])
            tx_sh_reg[k[1:0]] <= tx_buf_reg[k[1:0]];
          else
            tx_sh_reg[k[1:0]] <= 16'h0000;
          if (!tx_fresh_reg[k[1:0]])
            tx_unf_reg[k[1:0]] <= 1'b1;
          if (k[1:0] == ptr_reg && rse_reg[slot_reg])
            rx_buf_reg[k[1:0]] <= rx_val;
          else
            rx_buf_reg[k[1:0]] <= rx_sh_reg[k[1:0]];
          rx_new_reg[k[1:0]] <= 1'b1;
          // unread data is overwritten regardless
          if (rx_new_reg[k[1:0]] && !(rd && rx_hit && rx_off[1:0] == k[1:0]))
            rx_ovf_reg[k[1:0]] <= 1'b1;
        end
      end
      if (xfer)
        tx_empty_reg <= 1'b1;
      else if (wr && tx_hit)
        tx_empty_reg <= 1'b0;

      CODEC_IRQ_FLAG <= xfer;
      DMA_REQ <= xfer;
      if (xfer && CORE_SLEEP)
        WAKE_IRQ <= 1'b1;
      else if (!CORE_SLEEP)
        WAKE_IRQ <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: csb_top_properties.sv
// Purpose: port-level checks for the codec slot buffer block
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module csb_top_checker (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CORE_SLEEP,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_DATA_OE_N,
  input wire logic FRAME_SYNC_PIN_OUT,
  input wire logic FRAME_SYNC_PIN_OE_N,
  input wire logic CODEC_IRQ_FLAG,
  input wire logic DMA_REQ,
  input wire logic WAKE_IRQ
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);
  sequence req_taken;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence one_wait_answer;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  bus_answer_a: assert property (req_taken |=> one_wait_answer)
    else $error("bus answer not after one wait cycle");
  rdata_hold_a: assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
    else $error("read data moved without a read");
  irq_dma_a: assert property (CODEC_IRQ_FLAG == DMA_REQ)
    else $error("dma request differs from interrupt");
  irq_pulse_a: assert property (CODEC_IRQ_FLAG |=> !CODEC_IRQ_FLAG)
    else $error("interrupt pulse too long");
  wake_clear_a: assert property (!CORE_SLEEP |=> !WAKE_IRQ)
    else $error("wake stays up when awake");
  wake_set_a: assert property ($rose(CODEC_IRQ_FLAG) && $past(CORE_SLEEP) |-> WAKE_IRQ)
    else $error("no wake at transfer in sleep");
  reset_clear_a: assert property ($rose(RESET_N) |-> !CODEC_IRQ_FLAG && !WAKE_IRQ
      && AVS_WAITREQUEST && SERIAL_DATA_OE_N && FRAME_SYNC_PIN_OE_N)
    else $error("outputs not cleared by reset");
  idle_drive_a: assert property (SERIAL_DATA_OE_N |-> !SERIAL_DATA_OUT)
    else $error("data high while released");
  // enable may drop mid pulse on a role change, so release ends the check
  fs_width_a: assert property ($rose(FRAME_SYNC_PIN_OUT) && !FRAME_SYNC_PIN_OE_N
      |-> (FRAME_SYNC_PIN_OUT || FRAME_SYNC_PIN_OE_N) [*8])
    else $error("frame sync shorter than a bit");
endmodule
bind csb_top csb_top_checker csb_top_checker_i (.CLOCK(CLOCK), .RESET_N(RESET_N),
  .CORE_SLEEP(CORE_SLEEP), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SERIAL_DATA_OE_N(SERIAL_DATA_OE_N),
  .FRAME_SYNC_PIN_OUT(FRAME_SYNC_PIN_OUT), .FRAME_SYNC_PIN_OE_N(FRAME_SYNC_PIN_OE_N),
  .CODEC_IRQ_FLAG(CODEC_IRQ_FLAG), .DMA_REQ(DMA_REQ), .WAKE_IRQ(WAKE_IRQ));
`default_nettype wire

// file: test_codec_slot_buffer_control.sv
// Purpose: self-checking bench for the codec slot buffer block
// Assumes: waitrequest bus master, partner codec on the link pins
// Notes: loopback covers the master modes, the partner the slave mode
`timescale 1ns/100ps
`default_nettype none
`include "csb_defs.vh"
module test_codec_slot_buffer_control;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic core_sleep = 1'b0;
  logic core_idle = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic partner_on = 1'b0;
  logic [15:0] partner_word = 16'h0000;
  logic [15:0] q, w;
  logic got;
  logic [31:0] seed = 32'h00004C0F;
  logic [15:0] modes [3] = '{16'h0101, 16'h0127, 16'h0131};
  int mismatches = 0;
  int cmp_count = 0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, fs_out, fs_oe_n, bclk_out, bclk_oe_n, irq, wake_irq, pbclk, pfs, psd;
  wire fs_pin = !fs_oe_n ? fs_out : pfs;
  wire bclk_pin = !bclk_oe_n ? bclk_out : pbclk;
  always #12.5 clock = ~clock;
  csb_top csb_top_i (.CLOCK(clock), .RESET_N(reset_n), .CLK_EN(1'b1), .CORE_SLEEP(core_sleep),
    .CORE_IDLE(core_idle), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'h3),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .SERIAL_DATA_IN(psd),
    .SERIAL_DATA_OUT(), .SERIAL_DATA_OE_N(), .FRAME_SYNC_PIN_IN(fs_pin),
    .FRAME_SYNC_PIN_OUT(fs_out), .FRAME_SYNC_PIN_OE_N(fs_oe_n),
    .SERIAL_BIT_CLOCK_IN(bclk_pin), .SERIAL_BIT_CLOCK_OUT(bclk_out),
    .SERIAL_BIT_CLOCK_OE_N(bclk_oe_n), .CODEC_IRQ_FLAG(irq), .DMA_REQ(), .WAKE_IRQ(wake_irq));
  csb_codec_model csb_codec_model_i (.active(partner_on), .pattern(partner_word),
    .bit_clock(pbclk), .frame_sync(pfs), .data_out(psd));
  function automatic logic [15:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  function automatic logic [15:0] unf_word(input logic [15:0] c, input logic [15:0] last);
    return c[2] ? last : 16'h0000;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [15:0] dat);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, dat};
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) check("bus answer", 16'h0000, 16'h0001);
  endtask
  task automatic rd(input logic [3:0] adr);
    bus(1'b0, adr, 16'h0000);
  endtask
  task automatic wait_irq(input int limit);
    int n;
    n = 0;
    got = 1'b0;
    while (!got && n < limit) begin
      @(posedge clock);
      got = (irq === 1'b1);
      n++;
    end
  endtask
  task automatic next_irq();
    wait_irq(3000);
    check("interrupt", {15'h0000, got}, 16'h0001);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    rd(`CSB_REG_STATUS);
    check("status", q, 16'h0000);
    bus(1'b1, 4'hE, 16'hFFFF);
    rd(4'hE);
    check("unmapped", q, 16'h0000);
    $display("test reset finished");
    // one word buffer, so every transfer could serve a dma channel
    bus(1'b1, `CSB_REG_CTRL_B, 16'h0F10);
    bus(1'b1, `CSB_REG_TX_SLOT, 16'h0002);
    bus(1'b1, `CSB_REG_RX_SLOT, 16'h0002);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `CSB_REG_CTRL_A, modes[i]);
      next_irq();
      w = next_rand();
      bus(1'b1, `CSB_REG_TX_BUF0, w);
      next_irq();
      next_irq();
      rd(`CSB_REG_RX_BUF0);
      check("loopback word", q, w);
      rd(`CSB_REG_STATUS);
      check("status underflow", {12'h000, q[3:0]}, 16'h0003);
      next_irq();
      rd(`CSB_REG_RX_BUF0);
      check("underflow word", q, unf_word(modes[i], w));
      next_irq();
      next_irq();
      rd(`CSB_REG_STATUS);
      check("status overflow", {12'h000, q[3:0]}, 16'h000F);
      rd(`CSB_REG_RX_BUF0);
      bus(1'b1, `CSB_REG_TX_BUF0, next_rand());
      rd(`CSB_REG_STATUS);
      check("status serviced", {12'h000, q[3:0]}, 16'h0000);
      $display("test mode %h finished", modes[i]);
    end
    partner_word <= next_rand();
    partner_on <= 1'b1;
    core_sleep <= 1'b1;
    core_idle <= 1'b1;
    bus(1'b1, `CSB_REG_CTRL_B, 16'h0F00);
    bus(1'b1, `CSB_REG_TX_SLOT, 16'h0001);
    bus(1'b1, `CSB_REG_RX_SLOT, 16'h0001);
    bus(1'b1, `CSB_REG_CTRL_A, 16'h01C0);
    repeat (3) next_irq();
    check("wake", {15'h0000, wake_irq}, 16'h0001);
    check("pins released", {14'h0000, fs_oe_n, bclk_oe_n}, 16'h0003);
    rd(`CSB_REG_RX_BUF0);
    check("slave word", q, partner_word);
    rd(`CSB_REG_STATUS);
    check("slot field", {12'h000, q[11:8]}, 16'h0000);
    @(posedge clock);
    core_sleep <= 1'b0;
    repeat (2) @(posedge clock);
    check("wake cleared", {15'h0000, wake_irq}, 16'h0000);
    bus(1'b1, `CSB_REG_CTRL_A, 16'h01C8);
    wait_irq(1000);
    check("halted in idle", {15'h0000, got}, 16'h0000);
    core_idle <= 1'b0;
    next_irq();
    $display("test slave finished");
    tally_and_finish();
  end
endmodule
`default_nettype wire
